// ---- pcs_pkg.sv ----
package pcs_pkg;
  // register bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 10;
  typedef logic [IDX_W-1:0] pcs_idx_t;
  // printed offsets are register indices; byte address is four times the index
  localparam pcs_idx_t IDX_PLL_RATIO = 10'h032;
  localparam pcs_idx_t IDX_TOP_CLOCK = 10'h034;
  localparam pcs_idx_t IDX_ANALOG_STATUS = 10'h036;
  localparam pcs_idx_t IDX_IRQ_STATUS = 10'h040;
  localparam pcs_idx_t IDX_IRQ_MASK = 10'h041;
  // pll ratio layout
  localparam int RATIO_INT_HI = 15;
  localparam int RATIO_INT_LO = 11;
  localparam int RATIO_FRAC_HI = 10;
  localparam int RATIO_FRAC_LO = 0;
  localparam int INT_W = RATIO_INT_HI - RATIO_INT_LO + 1;
  localparam int FRAC_W = RATIO_FRAC_HI - RATIO_FRAC_LO + 1;
  localparam int OUT_CYC_W = INT_W + 1;
  localparam logic [REG_W-1:0] RATIO_RESET = 16'h5000;
  localparam logic [REG_W-1:0] RATIO_RW_MASK = 16'hFFFF;
  // top clock layout
  localparam int TOP_OSC_BIT = 11;
  localparam int TOP_HALVE_BIT = 3;
  localparam logic [REG_W-1:0] TOP_RESET = 16'h0000;
  localparam logic [REG_W-1:0] TOP_RW_MASK = 16'h0FFF;
  // analog status layout
  localparam int STATUS_LOCK_BIT = 4;
  // interrupt status and mask layout
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_LATE_WRITE = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RW_MASK = 3'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INT_OSC_PERIOD_NS = 1000;
  localparam int INT_OSC_CYCLES = (INT_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CNT_W = 7;
  localparam int LOCK_REF_TICKS = 64;
  localparam int LOCK_CNT_W = 7;
  localparam int SYNC_W = 3;
endpackage : pcs_pkg

// ---- pcs_pll_if.sv ----
`timescale 1ns/100ps
interface pcs_pll_if;
  logic ref_tick;
  logic power_on;
  logic [pcs_pkg::REG_W-1:0] ratio;
  logic locked;
  logic [pcs_pkg::OUT_CYC_W-1:0] out_cycles;
  modport core (
    input ref_tick,
    input power_on,
    input ratio,
    output locked,
    output out_cycles
  );
  modport ctrl (
    output ref_tick,
    output power_on,
    output ratio,
    input locked,
    input out_cycles
  );
endinterface : pcs_pll_if

// ---- pcs_pll_core.sv ----
`timescale 1ns/100ps
module pcs_pll_core #(
  parameter int LOCK_TICKS = pcs_pkg::LOCK_REF_TICKS // reference ticks until lock
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // async reset, active low
  pcs_pll_if.core pll // reference tick, ratio, lock and output count
);
  import pcs_pkg::*;

  typedef struct packed {
    logic [FRAC_W-1:0] phase;
    logic [LOCK_CNT_W-1:0] lock_cnt;
    logic locked;
    logic [OUT_CYC_W-1:0] out_cycles;
  } pcs_core_s;

  pcs_core_s st;
  pcs_core_s next_st;
  logic [FRAC_W:0] phase_sum;

  assign phase_sum = {1'b0, st.phase} + {1'b0, pll.ratio[RATIO_FRAC_HI:RATIO_FRAC_LO]};

  always_comb
  begin
    next_st = st;
    next_st.out_cycles = '0;
    if (!pll.power_on)
    begin
      next_st.phase = '0;
      next_st.lock_cnt = '0;
      next_st.locked = 1'b0;
    end
    else if (pll.ref_tick)
    begin
      // fraction accumulates in units of 1/2048
      next_st.phase = phase_sum[FRAC_W-1:0];
      next_st.out_cycles = {1'b0, pll.ratio[RATIO_INT_HI:RATIO_INT_LO]} + {{INT_W{1'b0}}, phase_sum[FRAC_W]};
      if (!st.locked)
      begin
        if (st.lock_cnt == LOCK_CNT_W'(LOCK_TICKS - 1))
        begin
          next_st.locked = 1'b1;
        end
        else
        begin
          next_st.lock_cnt = st.lock_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pll.locked = st.locked;
  assign pll.out_cycles = st.out_cycles;
endmodule : pcs_pll_core

// ---- pcs_pll_clock_setup.sv ----
`timescale 1ns/100ps
module pcs_pll_clock_setup #(
  parameter int LOCK_TICKS = pcs_pkg::LOCK_REF_TICKS, // reference ticks until lock
  parameter int OSC_CYCLES = pcs_pkg::INT_OSC_CYCLES // internal oscillator period in cycles
) (
  input wire logic i_clk_sys, // system clock, 50 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic [pcs_pkg::AXI_ADDR_W-1:0] i_awaddr, // write address
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [pcs_pkg::AXI_DATA_W-1:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // write byte strobes
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  output logic [1:0] o_bresp, // write response
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  input wire logic [pcs_pkg::AXI_ADDR_W-1:0] i_araddr, // read address
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  output logic [pcs_pkg::AXI_DATA_W-1:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output logic o_rvalid, // read data valid
  input wire logic i_rready, // read data ready
  input wire logic i_system_master_clock, // master clock pin
  input wire logic i_serial_audio_clk, // serial audio bit clock pin
  input wire logic i_pll_power_on, // pll power control, same clock domain
  output logic o_internal_osc_on, // internal oscillator running
  output logic o_master_clock_halve, // halving stage in effect
  output logic o_pll_reference_tick, // one pulse per pll reference cycle
  output logic [pcs_pkg::OUT_CYC_W-1:0] o_pll_out_cycles, // output cycles for last reference tick while powered, valid one cycle after it, else zero
  output logic o_pll_lock_flag, // pll locked
  output logic o_analog_clk_tick, // clock tick for zero-cross, short recovery, charge pump
  output logic o_irq // interrupt, active high level
);
  import pcs_pkg::*;

  localparam int OSC_WAIT = OSC_CYCLES + 1;

  typedef struct packed {
    logic [SYNC_W-1:0] mclk_sync;
    logic [SYNC_W-1:0] sclk_sync;
    logic halve_phase;
    logic ref_tick;
    logic [OSC_CNT_W-1:0] osc_cnt;
    logic analog_tick;
    logic [REG_W-1:0] pll_ratio;
    logic [REG_W-1:0] top_ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic lock_prev;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [AXI_DATA_W-1:0] rdata;
  } pcs_state_s;

  pcs_state_s st;
  pcs_state_s next_st;

  logic mclk_edge;
  logic sclk_edge;
  logic halve_eff;
  logic do_write;
  logic rd_take;
  pcs_idx_t wr_idx;
  pcs_idx_t rd_idx;
  logic late_write;
  logic lock_gain;
  logic lock_loss;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;

  pcs_pll_if pll ();

  function automatic pcs_idx_t reg_index(input logic [AXI_ADDR_W-1:0] addr);
    reg_index = addr[AXI_ADDR_W-1:2];
  endfunction : reg_index

  // registers are 16 bits wide, so only the two low byte lanes matter
  function automatic logic [REG_W-1:0] apply_strb(
    input logic [REG_W-1:0] old_val,
    input logic [REG_W-1:0] new_val,
    input logic [1:0] strb,
    input logic [REG_W-1:0] rw_mask
  );
    logic [REG_W-1:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & rw_mask;
    apply_strb = (old_val & ~lane) | (new_val & lane);
  endfunction : apply_strb

  // only the second synchroniser stage and its delayed copy feed edge detection
  assign mclk_edge = st.mclk_sync[1] & ~st.mclk_sync[2];
  assign sclk_edge = st.sclk_sync[1] & ~st.sclk_sync[2];
  // halving only takes effect with the pll powered
  assign halve_eff = st.top_ctrl[TOP_HALVE_BIT] & i_pll_power_on;
  assign do_write = st.aw_held & st.w_held & ~st.bvalid;
  assign rd_take = i_arvalid & ~st.rvalid;
  assign wr_idx = reg_index(st.aw_addr);
  assign rd_idx = reg_index(i_araddr);
  // a ratio write after power-on is flagged to software
  assign late_write = do_write && (wr_idx == IDX_PLL_RATIO) && i_pll_power_on;
  assign lock_gain = pll.locked & ~st.lock_prev;
  assign lock_loss = ~pll.locked & st.lock_prev;

  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_LOCK_GAIN] = lock_gain;
    irq_events[IRQ_LOCK_LOSS] = lock_loss;
    irq_events[IRQ_LATE_WRITE] = late_write;
  end

  assign irq_clear = (do_write && (wr_idx == IDX_IRQ_STATUS) && st.w_strb[0]) ? st.w_data[IRQ_W-1:0] : '0;

  always_comb
  begin
    next_st = st;
    next_st.mclk_sync = {st.mclk_sync[SYNC_W-2:0], i_system_master_clock};
    next_st.sclk_sync = {st.sclk_sync[SYNC_W-2:0], i_serial_audio_clk};

    // reference follows each master clock edge, or every second one
    // halving stage selected by the top clock register
    next_st.ref_tick = 1'b0;
    if (mclk_edge)
    begin
      if (halve_eff)
      begin
        next_st.halve_phase = ~st.halve_phase;
        next_st.ref_tick = st.halve_phase;
      end
      else
      begin
        next_st.halve_phase = 1'b0;
        next_st.ref_tick = 1'b1;
      end
    end

    // internal oscillator built from a divider of the system clock
    // with the oscillator on, analog tick keeps running whether or not the serial clock moves; off, it follows serial clock edges
    next_st.analog_tick = 1'b0;
    if (st.top_ctrl[TOP_OSC_BIT])
    begin
      if (st.osc_cnt == OSC_CNT_W'(OSC_CYCLES - 1))
      begin
        next_st.osc_cnt = '0;
        next_st.analog_tick = 1'b1;
      end
      else
      begin
        next_st.osc_cnt = st.osc_cnt + 1'b1;
      end
    end
    else
    begin
      next_st.osc_cnt = '0;
      next_st.analog_tick = sclk_edge;
    end

    // write channel: address and data taken in either order
    if (i_awvalid && !st.aw_held)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st.w_held)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    if (st.bvalid && i_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (do_write)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (wr_idx)
        IDX_PLL_RATIO:
        begin
          // integer part in the upper five bits
          next_st.pll_ratio = apply_strb(st.pll_ratio, st.w_data[REG_W-1:0], st.w_strb[1:0], RATIO_RW_MASK);
        end
        IDX_TOP_CLOCK:
        begin
          next_st.top_ctrl = apply_strb(st.top_ctrl, st.w_data[REG_W-1:0], st.w_strb[1:0], TOP_RW_MASK);
        end
        IDX_IRQ_MASK:
        begin
          // only the low status-sized slice of the 16-bit lane merge is kept
          next_st.irq_mask = IRQ_W'(apply_strb({{(REG_W-IRQ_W){1'b0}}, st.irq_mask}, st.w_data[REG_W-1:0],
                                               st.w_strb[1:0], {{(REG_W-IRQ_W){1'b0}}, IRQ_RW_MASK}));
        end
        IDX_ANALOG_STATUS, IDX_IRQ_STATUS:
        begin
          next_st.bresp = RESP_OKAY;
        end
        default:
        begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // a new event beats a clear in the same cycle
    next_st.irq_status = (st.irq_status & ~irq_clear) | irq_events;
    next_st.lock_prev = pll.locked;

    // read channel
    if (st.rvalid && i_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (rd_take)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = '0;
      case (rd_idx)
        IDX_PLL_RATIO:
        begin
          next_st.rdata[REG_W-1:0] = st.pll_ratio;
        end
        IDX_TOP_CLOCK:
        begin
          next_st.rdata[REG_W-1:0] = st.top_ctrl;
        end
        IDX_ANALOG_STATUS:
        begin
          // lock flag read live from the pll
          next_st.rdata[STATUS_LOCK_BIT] = pll.locked;
        end
        IDX_IRQ_STATUS:
        begin
          next_st.rdata[IRQ_W-1:0] = st.irq_status;
        end
        IDX_IRQ_MASK:
        begin
          next_st.rdata[IRQ_W-1:0] = st.irq_mask;
        end
        default:
        begin
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
      st.pll_ratio <= RATIO_RESET;
      st.top_ctrl <= TOP_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pll.ref_tick = st.ref_tick;
  assign pll.power_on = i_pll_power_on;
  assign pll.ratio = st.pll_ratio;

  pcs_pll_core #(
    .LOCK_TICKS(LOCK_TICKS)
  ) u_core (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .pll(pll.core)
  );

  assign o_awready = ~st.aw_held;
  assign o_wready = ~st.w_held;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = ~st.rvalid;
  assign o_rvalid = st.rvalid;
  assign o_rresp = st.rresp;
  assign o_rdata = st.rdata;
  assign o_internal_osc_on = st.top_ctrl[TOP_OSC_BIT];
  assign o_master_clock_halve = halve_eff;
  assign o_pll_reference_tick = st.ref_tick;
  assign o_pll_out_cycles = pll.out_cycles;
  assign o_pll_lock_flag = pll.locked;
  assign o_analog_clk_tick = st.analog_tick;
  assign o_irq = |(st.irq_status & st.irq_mask);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  chk_int_floor: assert property (
    (st.ref_tick && i_pll_power_on) |=> (pll.out_cycles >= {1'b0, $past(st.pll_ratio[RATIO_INT_HI:RATIO_INT_LO])})
  ) else $error("pll output count below integer ratio");

  chk_frac_carry: assert property (
    (st.ref_tick && i_pll_power_on) |=>
      (pll.out_cycles <= ({1'b0, $past(st.pll_ratio[RATIO_INT_HI:RATIO_INT_LO])} + 6'h01))
  ) else $error("pll output count above integer ratio plus one");

  chk_ref_pass: assert property (
    (mclk_edge && !halve_eff) |=> st.ref_tick
  ) else $error("unhalved master clock edge gave no reference tick");

  chk_halve_skip: assert property (
    (mclk_edge && halve_eff && !st.halve_phase) |=> !st.ref_tick ##1 !st.ref_tick
  ) else $error("halved master clock did not skip an edge");

  chk_halve_idle: assert property (
    (mclk_edge && !i_pll_power_on) |-> (!o_master_clock_halve ##1 st.ref_tick)
  ) else $error("halving acted while pll powered down");

  chk_osc_enable: assert property (
    (do_write && wr_idx == IDX_TOP_CLOCK && st.w_strb[1]) |=> (o_internal_osc_on == $past(st.w_data[TOP_OSC_BIT]))
  ) else $error("oscillator enable did not follow register write");

  chk_osc_running: assert property (
    (o_internal_osc_on && st.analog_tick) |-> ##[1:OSC_WAIT] (st.analog_tick || !o_internal_osc_on)
  ) else $error("analog tick stopped with oscillator enabled");

  chk_lock_read: assert property (
    (rd_take && rd_idx == IDX_ANALOG_STATUS) |=> (o_rdata[STATUS_LOCK_BIT] == $past(pll.locked))
  ) else $error("status read did not show lock flag");

  chk_lock_drop: assert property (
    !i_pll_power_on |=> !o_pll_lock_flag
  ) else $error("lock flag held with pll powered down");

  chk_late_flag: assert property (
    late_write |=> st.irq_status[IRQ_LATE_WRITE]
  ) else $error("late ratio write not flagged");

  cov_lock_rise: cover property ($rose(o_pll_lock_flag));
  cov_late_write: cover property (late_write);
  cov_status_read: cover property (rd_take && rd_idx == IDX_ANALOG_STATUS);
  cov_osc_tick: cover property (o_internal_osc_on && st.analog_tick);
endmodule : pcs_pll_clock_setup

// ---- pcs_clock_source.sv ----
`timescale 1ns/100ps
module pcs_clock_source #(
  parameter int HALF_NS = 100 // half period in ns
) (
  input wire logic i_enable, // run the clock
  output logic o_clk // generated clock
);
  initial o_clk = 1'b0;
  // rate below halving threshold
  // kept well under 17 MHz so the halving stage stays optional for software
  always
  begin
    #(HALF_NS);
    // a stopped source rests low instead of freezing mid-cycle
    if (i_enable)
      o_clk = ~o_clk;
    else
      o_clk = 1'b0;
  end
endmodule : pcs_clock_source

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import pcs_pkg::*;
  logic i_clk_sys, i_rst_n;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata, data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic mclk, sclk, mclk_en, sclk_en, power_on;
  logic osc_on, halve, ref_tick, lock, ana_tick, irq;
  logic [OUT_CYC_W-1:0] out_cyc;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0, ticks = 0, out_sum = 0, ana = 0, gap = 0;

  initial i_clk_sys = 1'b0;
  always #10 i_clk_sys = ~i_clk_sys;

  pcs_clock_source #(.HALF_NS(100)) mclk_src (.i_enable(mclk_en), .o_clk(mclk));
  pcs_clock_source #(.HALF_NS(80)) sclk_src (.i_enable(sclk_en), .o_clk(sclk));

  pcs_pll_clock_setup #(.LOCK_TICKS(4), .OSC_CYCLES(4)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_system_master_clock(mclk), .i_serial_audio_clk(sclk), .i_pll_power_on(power_on),
    .o_internal_osc_on(osc_on), .o_master_clock_halve(halve), .o_pll_reference_tick(ref_tick),
    .o_pll_out_cycles(out_cyc), .o_pll_lock_flag(lock), .o_analog_clk_tick(ana_tick), .o_irq(irq)
  );

  // tallies of pulse outputs, read by the scenarios at falling edges
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (ref_tick === 1'b1)
      ticks++;
    out_sum += int'(out_cyc);
    if (ana_tick === 1'b1)
      ana++;
  end

  task automatic end_of_test;
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input pcs_idx_t idx, input logic [15:0] d);
    logic aw_go, w_go, b_go;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    repeat (100)
    begin
      @(negedge i_clk_sys);
      aw_go = awvalid & awready;
      w_go = wvalid & wready;
      b_go = (bvalid === 1'b1);
      resp = bresp;
      @(posedge i_clk_sys);
      if (aw_go)
        awvalid <= 1'b0;
      if (w_go)
        wvalid <= 1'b0;
      if (b_go)
        return;
    end
    miscompares++;
  endtask : wr

  task automatic rd(input pcs_idx_t idx);
    logic ar_go, r_go;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    repeat (100)
    begin
      @(negedge i_clk_sys);
      ar_go = arvalid & arready;
      r_go = (rvalid === 1'b1);
      data = rdata;
      resp = rresp;
      @(posedge i_clk_sys);
      if (ar_go)
        arvalid <= 1'b0;
      if (r_go)
        return;
    end
    miscompares++;
  endtask : rd

  // cycles spanned by k reference ticks, measured tick edge to tick edge
  task automatic wait_ticks(input int k);
    int t0, c0, n;
    n = 0;
    @(negedge i_clk_sys);
    t0 = ticks;
    while (ticks < t0 + 1 && n < 3000)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    c0 = cyc;
    while (ticks < t0 + 1 + k && n < 3000)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    gap = cyc - c0;
    @(posedge i_clk_sys);
  endtask : wait_ticks

  task automatic count_ana(input int span);
    @(negedge i_clk_sys);
    ana = 0;
    repeat (span) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
  endtask : count_ana

  task automatic s_reset;
    rd(IDX_PLL_RATIO);
    check(data, 32'h0000_5000, "ratio reset");
    rd(IDX_TOP_CLOCK);
    check(data, 32'h0000_0000, "top reset");
    rd(IDX_ANALOG_STATUS);
    check(data, 32'h0000_0000, "status reset");
    rd(10'h3FF);
    check(32'(resp), 32'(RESP_SLVERR), "unmapped read");
  endtask : s_reset

  task automatic s_top;
    wr(IDX_TOP_CLOCK, 16'hFFFF);
    rd(IDX_TOP_CLOCK);
    check(data, 32'h0000_0FFF, "top readback");
    check(32'(osc_on), 32'h0000_0001, "osc enable");
    check(32'(halve), 32'h0000_0000, "halve while off");
    wait_ticks(4);
    check(32'(gap), 32'd40, "ticks unhalved");
    count_ana(40);
    check(32'(ana), 32'd10, "osc ticks");
  endtask : s_top

  task automatic s_pll;
    // ratio 2.5 stands in for target over reference at this slow master clock
    wr(IDX_TOP_CLOCK, 16'h0000);
    wr(IDX_PLL_RATIO, 16'h1400);
    check(32'(resp), 32'(RESP_OKAY), "ratio write response");
    power_on <= 1'b1;
    @(negedge i_clk_sys);
    ticks = 0;
    out_sum = 0;
    while (ticks < 4 && cyc < 5000) @(negedge i_clk_sys);
    repeat (2) @(negedge i_clk_sys);
    check(32'(out_sum), 32'd10, "pll output cycles");
    @(posedge i_clk_sys);
    wait_ticks(2);
    rd(IDX_ANALOG_STATUS);
    check(data, 32'h0000_0010, "lock flag");
    check(32'(lock), 32'h0000_0001, "lock pin");
    rd(IDX_IRQ_STATUS);
    check(data, 32'h0000_0001, "lock event");
    check(32'(irq), 32'h0000_0000, "irq masked");
    wr(IDX_IRQ_MASK, 16'h0007);
    repeat (2) @(posedge i_clk_sys);
    check(32'(irq), 32'h0000_0001, "irq raised");
    wr(IDX_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge i_clk_sys);
    check(32'(irq), 32'h0000_0000, "irq cleared");
    wr(IDX_TOP_CLOCK, 16'h0008);
    repeat (2) @(posedge i_clk_sys);
    check(32'(halve), 32'h0000_0001, "halve on");
    wait_ticks(4);
    check(32'(gap), 32'd80, "ticks halved");
    wr(IDX_PLL_RATIO, 16'h5000);
    rd(IDX_IRQ_STATUS);
    check(data, 32'h0000_0004, "late ratio write");
    power_on <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    rd(IDX_ANALOG_STATUS);
    check(data, 32'h0000_0000, "lock dropped");
    check(32'(lock), 32'h0000_0000, "lock pin dropped");
    rd(IDX_IRQ_STATUS);
    check(data, 32'h0000_0006, "lock lost event");
    wr(IDX_IRQ_STATUS, 16'h0007);
    wr(IDX_TOP_CLOCK, 16'h0000);
  endtask : s_pll

  task automatic s_serial;
    // oscillator left off while the serial clock runs
    sclk_en <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    count_ana(80);
    check(32'(ana), 32'd10, "serial ticks");
    sclk_en <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    count_ana(40);
    check(32'(ana), 32'd0, "no clock no ticks");
  endtask : s_serial

  initial
  begin
    i_rst_n = 1'b0;
    {awvalid, wvalid, arvalid, power_on, sclk_en} = '0;
    {bready, rready, mclk_en} = 3'h7;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    s_reset;
    s_top;
    s_pll;
    s_serial;
    end_of_test;
  end

  initial
  begin
    #(20 * 20000);
    miscompares++;
    end_of_test;
  end
endmodule : testbench
